/* rie_defs.svh */
/*
  Offsets, field positions, reset values and limits of the rotary
  interval event logic. Definitions only; included by its bare name.
*/
// How it works
// - interval divider holds whole degrees; only 10 to 180 are used
// - current interval readable at 0x12, from zero to 360/divider minus one
// - writing one to zero bit takes present angle as zero, then self-clears
// - bit 3 of rotation control set suppresses interval events
// - every tracked change of interval number with events enabled raises an event; a host write at 0x12 does not
// - offset, reset zero, shifts the angle reference by 0 to 359 degrees
// - one degree hysteresis: rise one degree past boundary, fall below it
// - timer counts down from preload while counter adds degrees moved
// - counter threshold is degrees of movement needed for a movement event
// - zero timer preload wakes on movement only; awake reloads 31
// - touch wakeup: wake on touch, repeat ready while touched, ignore rest
// - interval events wake on interval change and give ready in normal
// - with interval and hall events both enabled, hall events win
// - hall events wake and report on counter-before-timer in low power
// - stream option: wake on source, stream at report rate, stop in low
// - all three sources disabled means no wheel events at all
// - in event mode ready follows a configured event, and also report ticks with the stream option
// - in streaming mode ready follows every report tick
`ifndef RIE_DEFS_SVH
`define RIE_DEFS_SVH
`define RIE_ADDR_INTERVAL 8'h12
`define RIE_ADDR_ROT_CTRL 8'h70
`define RIE_ADDR_PRELOAD 8'h7C
`define RIE_ADDR_DIVIDER 8'h7D
`define RIE_ADDR_OFFS_LO 8'h7E
`define RIE_ADDR_OFFS_HI 8'h7F
`define RIE_ADDR_MOVE 8'h8F
`define RIE_ROT_RESET 8'h14
`define RIE_DIV_RESET 8'h03
`define RIE_PRELOAD_RESET 8'h4A
`define RIE_OFFS_RESET 16'h0000
`define RIE_ROT_WRMASK 8'hFD
`define RIE_BIT_HALL_UI_DIS 7
`define RIE_BIT_INT_UI_DIS 6
`define RIE_BIT_ZERO 5
`define RIE_BIT_HALL_EV_DIS 4
`define RIE_BIT_INT_EV_DIS 3
`define RIE_BIT_TOUCH_WAKE 0
`define RIE_DIV_MIN 8'h0A
`define RIE_DIV_MAX 8'hB4
`define RIE_FULL_TURN 10'h168
`define RIE_AWAKE_PRELOAD 5'h1F
`endif

/* rie_pkg.sv */
/*
  Types of the rotary interval event logic.
  Assumes rie_defs.svh carries every number.
*/
package rie_pkg;
  typedef enum logic [0:0] {DIV_IDLE, DIV_RUN} rie_div_state_t;
  typedef enum logic [1:0] {SRC_NONE, SRC_TOUCH, SRC_HALL, SRC_INTERVAL}
    rie_src_t;
endpackage : rie_pkg

/* rie_divider.sv */
/*
  Restoring serial divider, one quotient bit per clock.
  Assumes start only while not busy and a nonzero divisor.
*/
`timescale 1ns/1ps
module rie_divider #(
  parameter int NUM_W = 9,
  parameter int DEN_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [NUM_W-1:0] dividend,
  input wire logic [DEN_W-1:0] divisor,
  output logic busy,
  output logic done,
  output logic [NUM_W-1:0] quotient
);
  localparam int CNT_W = $clog2(NUM_W + 1);
  rie_pkg::rie_div_state_t state_reg;
  logic [DEN_W-1:0] rem_reg;
  logic [NUM_W-1:0] num_reg;
  logic [DEN_W-1:0] den_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic done_reg;
  logic [NUM_W-1:0] quot_reg;
  wire [DEN_W:0] trial = {rem_reg, num_reg[NUM_W-1]};
  wire fits = trial >= {1'b0, den_reg};
  wire [DEN_W:0] trial_sub = trial - {1'b0, den_reg};
  wire [DEN_W-1:0] rem_next = fits ? trial_sub[DEN_W-1:0] : trial[DEN_W-1:0];
  wire [NUM_W-1:0] num_next = {num_reg[NUM_W-2:0], fits};
  wire last = cnt_reg == CNT_W'(1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= rie_pkg::DIV_IDLE;
      rem_reg <= '0;
      num_reg <= '0;
      den_reg <= '0;
      cnt_reg <= '0;
      done_reg <= 1'b0;
      quot_reg <= '0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        rie_pkg::DIV_IDLE: begin
          if (start) begin
            rem_reg <= '0;
            num_reg <= dividend;
            den_reg <= divisor;
            cnt_reg <= CNT_W'(NUM_W);
            state_reg <= rie_pkg::DIV_RUN;
          end
        end
        rie_pkg::DIV_RUN: begin
          rem_reg <= rem_next;
          num_reg <= num_next;
          cnt_reg <= cnt_reg - CNT_W'(1);
          if (last) begin
            quot_reg <= num_next;
            done_reg <= 1'b1;
            state_reg <= rie_pkg::DIV_IDLE;
          end
        end
        default: state_reg <= rie_pkg::DIV_IDLE;
      endcase
    end
  end

  assign busy = state_reg == rie_pkg::DIV_RUN;
  assign done = done_reg;
  assign quotient = quot_reg;
endmodule : rie_divider

/* rie_interval_events.sv */
/*
  Rotary interval and wheel event logic: interval number with offset and
  hysteresis, zero command, movement counter and timer, event source
  selection and the ready and wake pulses.
  Assumes a measured angle 0..359 with a valid pulse per sensing cycle,
  a report tick at the active report rate, and power mode, event mode and
  stream option given as levels by the surrounding device.
*/
`timescale 1ns/1ps
`include "rie_defs.svh"
module rie_interval_events (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic [8:0] ANGLE_DEG,
  input wire logic ANGLE_VALID,
  input wire logic CAPACITIVE_CHANNEL_ZERO_TOUCH,
  input wire logic LOW_POWER,
  input wire logic EVENT_MODE,
  input wire logic STREAM_NORMAL,
  input wire logic REPORT_TICK,
  output logic READY,
  output logic WAKE,
  output logic [7:0] INTERVAL_INDEX
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = a == b;
  endfunction : hit

  logic [7:0] rot_ctrl_reg;
  logic [7:0] div_reg;
  logic [15:0] offset_reg;
  logic [7:0] interval_reg;
  logic [7:0] preload_reg;
  logic [2:0] move_cnt_reg;
  logic [4:0] move_tmr_reg;
  logic [8:0] prev_angle_reg;
  logic prev_valid_reg;
  logic [8:0] adj_hold_reg;
  logic touch_prev_reg;
  logic ready_reg;
  logic wake_reg;
  logic [7:0] rdata_reg;

  // register port decode
  wire wr_int = REG_WR && hit(REG_ADDR, `RIE_ADDR_INTERVAL);
  wire wr_rot = REG_WR && hit(REG_ADDR, `RIE_ADDR_ROT_CTRL);
  wire wr_pre = REG_WR && hit(REG_ADDR, `RIE_ADDR_PRELOAD);
  wire wr_div = REG_WR && hit(REG_ADDR, `RIE_ADDR_DIVIDER);

  // control fields
  wire zero_req = rot_ctrl_reg[`RIE_BIT_ZERO];
  wire touch_en = rot_ctrl_reg[`RIE_BIT_TOUCH_WAKE];
  wire hall_ev_en = !rot_ctrl_reg[`RIE_BIT_HALL_EV_DIS];
  wire int_ev_en = !rot_ctrl_reg[`RIE_BIT_INT_EV_DIS];
  wire int_ui_en = !rot_ctrl_reg[`RIE_BIT_INT_UI_DIS];
  wire hall_ui_en = !rot_ctrl_reg[`RIE_BIT_HALL_UI_DIS];
  wire [4:0] tmr_preload = preload_reg[4:0];
  wire [2:0] cnt_thresh = preload_reg[7:5];

  // reset value 3 is out of range, so intervals freeze until rewritten
  wire div_ok = (div_reg >= `RIE_DIV_MIN) && (div_reg <= `RIE_DIV_MAX);

  // zero command: offset that maps the present angle onto zero
  wire [9:0] angle_w = {1'b0, ANGLE_DEG};
  wire [9:0] zero_diff = `RIE_FULL_TURN - angle_w;
  wire [15:0] zero_offset = (ANGLE_DEG == 9'h000) ? 16'h0000 :
                            {7'h00, zero_diff[8:0]};
  wire [7:0] rot_wr_val = REG_WDATA & `RIE_ROT_WRMASK;
  // a host write in the clearing cycle wins: it is a fresh request
  wire [7:0] rot_ctrl_next = wr_rot ? rot_wr_val :
                             zero_req ? (rot_ctrl_reg &
                                         ~(8'h01 << `RIE_BIT_ZERO)) :
                             rot_ctrl_reg;
  wire [15:0] offset_next = zero_req ? zero_offset : offset_reg;

  // adjusted angle, modulo one turn
  wire [9:0] adj_sum = angle_w + {1'b0, offset_reg[8:0]};
  wire [9:0] adj_wrap = (adj_sum >= `RIE_FULL_TURN) ?
                        adj_sum - `RIE_FULL_TURN : adj_sum;
  wire [8:0] adj_angle = adj_wrap[8:0];

  // serial division of the adjusted angle by the interval size
  wire div_busy;
  wire div_done;
  wire [8:0] quot;
  wire div_start = ANGLE_VALID && div_ok && int_ui_en && !div_busy;

  rie_divider #(
    .NUM_W(9),
    .DEN_W(8)
  ) u_div (
    .clk(CORE_CLK),
    .rst(RST),
    .start(div_start),
    .dividend(adj_angle),
    .divisor(div_reg),
    .busy(div_busy),
    .done(div_done),
    .quotient(quot)
  );

  // a short last interval is folded into the one before it
  wire [9:0] quot_inc = {1'b0, quot} + 10'h001;
  wire [17:0] span_end = quot_inc * div_reg;
  wire fold = (span_end > {8'h00, `RIE_FULL_TURN}) && (quot != 9'h000);
  wire [8:0] cand = fold ? quot - 9'h001 : quot;
  wire [16:0] cand_base = cand * div_reg;
  wire going_up = cand > {1'b0, interval_reg};
  wire going_down = cand < {1'b0, interval_reg};
  // rise only one degree past the boundary, fall as soon as below it
  wire up_ok = {8'h00, adj_hold_reg} >= cand_base + 17'h0_0001;
  wire accept = going_down || (going_up && up_ok);
  wire interval_change = div_done && div_ok && accept;
  wire int_event = interval_change && int_ev_en;
  wire [7:0] interval_next = wr_int ? REG_WDATA :
                             interval_change ? cand[7:0] :
                             interval_reg;

  // movement: degrees moved since the last sample, shortest way round
  wire [9:0] prev_w = {1'b0, prev_angle_reg};
  wire [9:0] raw_d = (angle_w >= prev_w) ? angle_w - prev_w :
                     prev_w - angle_w;
  wire [9:0] min_d = (raw_d > (`RIE_FULL_TURN >> 1)) ?
                     `RIE_FULL_TURN - raw_d : raw_d;
  wire sample = ANGLE_VALID && prev_valid_reg && hall_ui_en;
  wire [10:0] cnt_sum = {8'h00, move_cnt_reg} + {1'b0, min_d};
  wire [2:0] cnt_sat = (cnt_sum > 11'h007) ? 3'h7 : cnt_sum[2:0];
  wire timed = tmr_preload != 5'h00;
  wire move_event = sample && (cnt_thresh != 3'h0) &&
                    (cnt_sum >= {8'h00, cnt_thresh}) &&
                    (!timed || move_tmr_reg != 5'h00);
  wire tmr_expire = sample && timed && !move_event &&
                    (move_tmr_reg <= 5'h01);
  wire [2:0] move_cnt_next = (move_event || tmr_expire) ? 3'h0 :
                             sample ? cnt_sat : move_cnt_reg;
  wire [4:0] move_tmr_next = (move_event || tmr_expire) ? tmr_preload :
                             (sample && timed) ? move_tmr_reg - 5'h01 :
                             move_tmr_reg;
  // awake reload overrides the timer field of a host write, as the wake scheme expects; the threshold bits are kept
  wire [7:0] preload_wr = wr_pre ? REG_WDATA : preload_reg;
  wire [7:0] preload_next = !LOW_POWER ?
                            {preload_wr[7:5], `RIE_AWAKE_PRELOAD} :
                            preload_wr;

  // event source: touch first, hall over interval, else nothing
  wire rie_pkg::rie_src_t src = touch_en ? rie_pkg::SRC_TOUCH :
                                hall_ev_en ? rie_pkg::SRC_HALL :
                                int_ev_en ? rie_pkg::SRC_INTERVAL :
                                rie_pkg::SRC_NONE;
  wire touch_now = CAPACITIVE_CHANNEL_ZERO_TOUCH;
  wire touch_rise = touch_now && !touch_prev_reg;
  logic ev_fire;
  always_comb begin
    case (src)
      rie_pkg::SRC_TOUCH: ev_fire = LOW_POWER ? touch_rise :
                                    (REPORT_TICK && touch_now);
      rie_pkg::SRC_HALL: ev_fire = move_event;
      rie_pkg::SRC_INTERVAL: ev_fire = int_event;
      default: ev_fire = 1'b0;
    endcase
  end
  // hall events also report in low power; the others only wake there
  wire ev_ready = ev_fire &&
                  (!LOW_POWER || src == rie_pkg::SRC_HALL);
  wire stream_ready = STREAM_NORMAL && !LOW_POWER && REPORT_TICK &&
                      src != rie_pkg::SRC_NONE;
  wire ready_next = EVENT_MODE ? (ev_ready || stream_ready) :
                    REPORT_TICK;
  wire wake_next = EVENT_MODE && LOW_POWER && ev_fire;

  // read data, one cycle behind the address
  logic [7:0] rdata_next;
  always_comb begin
    case (REG_ADDR)
      `RIE_ADDR_INTERVAL: rdata_next = interval_reg;
      `RIE_ADDR_ROT_CTRL: rdata_next = rot_ctrl_reg;
      `RIE_ADDR_PRELOAD: rdata_next = preload_reg;
      `RIE_ADDR_DIVIDER: rdata_next = div_reg;
      `RIE_ADDR_OFFS_LO: rdata_next = offset_reg[7:0];
      `RIE_ADDR_OFFS_HI: rdata_next = offset_reg[15:8];
      `RIE_ADDR_MOVE: rdata_next = {move_cnt_reg, move_tmr_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rot_ctrl_reg <= `RIE_ROT_RESET;
      div_reg <= `RIE_DIV_RESET;
      offset_reg <= `RIE_OFFS_RESET;
      interval_reg <= 8'h00;
      preload_reg <= `RIE_PRELOAD_RESET;
    end else begin
      rot_ctrl_reg <= rot_ctrl_next;
      div_reg <= wr_div ? REG_WDATA : div_reg;
      offset_reg <= offset_next;
      interval_reg <= interval_next;
      preload_reg <= preload_next;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      move_cnt_reg <= 3'h0;
      move_tmr_reg <= 5'h00;
      prev_angle_reg <= 9'h000;
      prev_valid_reg <= 1'b0;
      adj_hold_reg <= 9'h000;
      touch_prev_reg <= 1'b0;
    end else begin
      move_cnt_reg <= move_cnt_next;
      move_tmr_reg <= move_tmr_next;
      prev_angle_reg <= ANGLE_VALID ? ANGLE_DEG : prev_angle_reg;
      prev_valid_reg <= prev_valid_reg || ANGLE_VALID;
      adj_hold_reg <= div_start ? adj_angle : adj_hold_reg;
      touch_prev_reg <= touch_now;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ready_reg <= 1'b0;
      wake_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ready_reg <= ready_next;
      wake_reg <= wake_next;
      rdata_reg <= rdata_next;
    end
  end

  assign READY = ready_reg;
  assign WAKE = wake_reg;
  assign REG_RDATA = rdata_reg;
  assign INTERVAL_INDEX = interval_reg;

  // checks on the design's own behaviour
  sequence zero_cmd_s;
    wr_rot && REG_WDATA[`RIE_BIT_ZERO] ##1 zero_req && !wr_rot;
  endsequence

  sequence awake_hold_s;
    !LOW_POWER [*2];
  endsequence

  zero_clear_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    zero_cmd_s |=> !zero_req && offset_reg == $past(zero_offset))
    else $error("zero command did not load offset and clear itself");

  int_gate_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    rot_ctrl_reg[`RIE_BIT_INT_EV_DIS] && !touch_en && !hall_ev_en &&
      EVENT_MODE && interval_change |=> !READY && !WAKE)
    else $error("interval event passed while disabled");

  int_event_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    interval_reg != $past(interval_reg) && !$past(wr_int) &&
      $past(int_ev_en) |-> $past(int_event))
    else $error("interval changed without an event");

  offset_range_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    offset_reg < {6'h00, `RIE_FULL_TURN})
    else $error("offset outside one turn");

  hyst_up_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    interval_reg > $past(interval_reg) && !$past(wr_int) &&
      $stable(div_reg) |->
      {8'h00, $past(adj_hold_reg)} > interval_reg * div_reg)
    else $error("interval rose without one degree past boundary");

  interval_range_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    interval_change |=> {10'h000, interval_reg} * div_reg <
      {8'h00, `RIE_FULL_TURN})
    else $error("interval number beyond last interval");

  move_reload_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    move_event |=> move_cnt_reg == 3'h0 &&
      move_tmr_reg == $past(tmr_preload))
    else $error("movement event did not restart counter and timer");

  awake_load_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    awake_hold_s |-> tmr_preload == `RIE_AWAKE_PRELOAD)
    else $error("awake wheel did not reload timer preload");

  touch_only_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    EVENT_MODE && touch_en && !LOW_POWER && !REPORT_TICK |=> !READY)
    else $error("ready without touch report in touch mode");

  hall_prio_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    !touch_en && hall_ev_en && int_ev_en && int_event && !move_event &&
      EVENT_MODE && !STREAM_NORMAL |=> !READY && !WAKE)
    else $error("interval event served while hall events enabled");

  none_quiet_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    EVENT_MODE && src == rie_pkg::SRC_NONE |=> !READY && !WAKE)
    else $error("event raised with all sources disabled");

  stream_mode_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    !EVENT_MODE |=> READY == $past(REPORT_TICK))
    else $error("streaming ready does not follow report tick");

  int_ready_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    EVENT_MODE && src == rie_pkg::SRC_INTERVAL && int_event |=>
      READY == !$past(LOW_POWER) && WAKE == $past(LOW_POWER))
    else $error("interval change gave wrong ready or wake");

  hall_event_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    EVENT_MODE && src == rie_pkg::SRC_HALL && move_event |=>
      READY && WAKE == $past(LOW_POWER))
    else $error("movement event gave wrong ready or wake");

  touch_wake_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    EVENT_MODE && touch_en && LOW_POWER && touch_rise |=> WAKE)
    else $error("touch in low power did not wake");

  div_freeze_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    !div_ok && !wr_int |=> $stable(interval_reg))
    else $error("interval moved with divider out of range");

  stream_opt_a: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    EVENT_MODE && STREAM_NORMAL && !LOW_POWER && REPORT_TICK &&
      src != rie_pkg::SRC_NONE |=> READY)
    else $error("stream option missed a report tick");
endmodule : rie_interval_events

/* rie_host.sv */
/*
  Host controller model: register writes, reads and the event mode level.
  Assumes the register port of rie_interval_events and its one-cycle
  read latency.
*/
`timescale 1ns/1ps
`include "rie_defs.svh"
module rie_host (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  output logic event_mode
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    event_mode = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    // stale data must never look like a valid write
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    d = reg_rdata;
  endtask : rd

  // divider leaves its out-of-range reset value before events are trusted
  task automatic setup(input logic [7:0] rot, input logic [7:0] div);
    wr(`RIE_ADDR_ROT_CTRL, rot);
    wr(`RIE_ADDR_DIVIDER, div);
    event_mode = 1'b1;
  endtask : setup

  task automatic mode(input logic on);
    event_mode = on;
  endtask : mode
endmodule : rie_host

/* rie_interval_events_bench.sv */
/*
  Self-checking bench of rie_interval_events: registers, interval steps,
  zero command, event sources, streaming and movement events.
  Assumes rie_host as register master and a 200 MHz core clock.
*/
`timescale 1ns/1ps
`include "rie_defs.svh"
module rie_interval_events_bench;
  logic clk, rst, wr, valid, touch, low_power, ev, stream, tick;
  logic ready, wake;
  logic [7:0] addr, wdata, rdata, index;
  logic [8:0] angle;
  int fails = 0;
  int compares = 0;
  int rdy_n = 0;
  int wak_n = 0;

  rie_interval_events uut (
    .CORE_CLK(clk),
    .RST(rst),
    .REG_ADDR(addr),
    .REG_WR(wr),
    .REG_WDATA(wdata),
    .REG_RDATA(rdata),
    .ANGLE_DEG(angle),
    .ANGLE_VALID(valid),
    .CAPACITIVE_CHANNEL_ZERO_TOUCH(touch),
    .LOW_POWER(low_power),
    .EVENT_MODE(ev),
    .STREAM_NORMAL(stream),
    .REPORT_TICK(tick),
    .READY(ready),
    .WAKE(wake),
    .INTERVAL_INDEX(index)
  );

  rie_host host (
    .core_clk(clk),
    .reg_addr(addr),
    .reg_wr(wr),
    .reg_wdata(wdata),
    .reg_rdata(rdata),
    .event_mode(ev)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // pulses are one cycle wide, so counting at each edge sees every one
  always @(posedge clk) begin
    if (ready === 1'b1)
      rdy_n++;
    if (wake === 1'b1)
      wak_n++;
  end

  task automatic test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    check($sformatf("register %h", a), {8'h00, d}, {8'h00, exp});
  endtask : rdchk

  // one sample, then long enough for the divide and the event pulse
  task automatic step(input logic [8:0] a, input logic [7:0] idx,
      input int dr, input int dw);
    int r0;
    int w0;
    r0 = rdy_n;
    w0 = wak_n;
    @(posedge clk);
    #1;
    angle = a;
    valid = 1'b1;
    @(posedge clk);
    #1;
    valid = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    check("interval", {8'h00, index}, {8'h00, idx});
    check("ready count", 16'(rdy_n - r0), 16'(dr));
    check("wake count", 16'(wak_n - w0), 16'(dw));
  endtask : step

  task automatic ticks(input int n, input int dr);
    int r0;
    r0 = rdy_n;
    repeat (n) begin
      @(posedge clk);
      #1;
      tick = 1'b1;
      @(posedge clk);
      #1;
      tick = 1'b0;
    end
    repeat (3) @(posedge clk);
    #1;
    check("tick ready count", 16'(rdy_n - r0), 16'(dr));
  endtask : ticks

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done();
  end

  initial begin
    logic [7:0] ra [7];
    logic [7:0] rv [7];
    int w;
    ra = '{`RIE_ADDR_ROT_CTRL, `RIE_ADDR_DIVIDER, `RIE_ADDR_OFFS_LO,
      `RIE_ADDR_OFFS_HI, `RIE_ADDR_PRELOAD, `RIE_ADDR_INTERVAL, 8'h33};
    rv = '{8'h14, 8'h03, 8'h00, 8'h00, 8'h5F, 8'h00, 8'h00};
    rst = 1'b1;
    valid = 1'b0;
    touch = 1'b0;
    low_power = 1'b0;
    stream = 1'b0;
    tick = 1'b0;
    angle = 9'h000;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rdchk(ra[i], rv[i]);
    end
    host.wr(`RIE_ADDR_OFFS_LO, 8'hAA);
    rdchk(`RIE_ADDR_OFFS_LO, 8'h00);
    step(9'h064, 8'h00, 0, 0);
    host.setup(8'h14, 8'h24);
    step(9'h064, 8'h02, 1, 0);
    step(9'h06C, 8'h02, 0, 0);
    step(9'h06D, 8'h03, 1, 0);
    step(9'h06C, 8'h03, 0, 0);
    step(9'h06B, 8'h02, 1, 0);
    step(9'h000, 8'h00, 1, 0);
    step(9'h167, 8'h09, 1, 0);
    rdchk(`RIE_ADDR_INTERVAL, 8'h09);
    host.wr(`RIE_ADDR_DIVIDER, 8'hB4);
    step(9'h0C8, 8'h01, 1, 0);
    host.wr(`RIE_ADDR_DIVIDER, 8'h09);
    step(9'h00A, 8'h01, 0, 0);
    host.wr(`RIE_ADDR_DIVIDER, 8'h0A);
    step(9'h163, 8'h23, 1, 0);
    host.wr(`RIE_ADDR_DIVIDER, 8'h24);
    host.wr(`RIE_ADDR_ROT_CTRL, 8'h1C);
    step(9'h032, 8'h01, 0, 0);
    host.wr(`RIE_ADDR_ROT_CTRL, 8'h14);
    low_power = 1'b1;
    step(9'h064, 8'h02, 0, 1);
    low_power = 1'b0;
    host.wr(`RIE_ADDR_ROT_CTRL, 8'h34);
    rdchk(`RIE_ADDR_ROT_CTRL, 8'h14);
    rdchk(`RIE_ADDR_OFFS_LO, 8'h04);
    rdchk(`RIE_ADDR_OFFS_HI, 8'h01);
    step(9'h08C, 8'h01, 1, 0);
    host.mode(1'b0);
    ticks(2, 2);
    host.mode(1'b1);
    ticks(1, 0);
    stream = 1'b1;
    ticks(2, 2);
    low_power = 1'b1;
    ticks(1, 0);
    low_power = 1'b0;
    host.wr(`RIE_ADDR_ROT_CTRL, 8'h18);
    ticks(1, 0);
    stream = 1'b0;
    step(9'h12C, 8'h05, 0, 0);
    host.wr(`RIE_ADDR_ROT_CTRL, 8'h1D);
    touch = 1'b1;
    ticks(3, 3);
    step(9'h00A, 8'h07, 0, 0);
    touch = 1'b0;
    low_power = 1'b1;
    w = wak_n;
    repeat (3) @(posedge clk);
    #1;
    touch = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("touch wake", 16'(wak_n - w), 16'h0001);
    touch = 1'b0;
    low_power = 1'b0;
    host.wr(`RIE_ADDR_PRELOAD, 8'hE0);
    host.wr(`RIE_ADDR_ROT_CTRL, 8'h04);
    rdchk(`RIE_ADDR_PRELOAD, 8'hFF);
    step(9'h0CD, 8'h02, 1, 0);
    for (int i = 0; i < 3; i++) begin
      step(9'h0CE + 9'(i), 8'h02, 0, 0);
    end
    step(9'h0D1, 8'h03, 0, 0);
    step(9'h0D2, 8'h03, 0, 0);
    step(9'h0D3, 8'h03, 0, 0);
    step(9'h0D4, 8'h03, 1, 0);
    rdchk(`RIE_ADDR_MOVE, 8'h1F);
    low_power = 1'b1;
    step(9'h12C, 8'h05, 1, 1);
    // zero timer preload: one degree meets threshold one, no timer needed
    host.wr(`RIE_ADDR_PRELOAD, 8'h20);
    step(9'h12D, 8'h05, 1, 1);
    // timer of two runs out before seven degrees, count starts over
    host.wr(`RIE_ADDR_PRELOAD, 8'hE2);
    for (int i = 0; i < 3; i++) begin
      step(9'h12E + 9'(i), 8'h05, 0, 0);
    end
    rdchk(`RIE_ADDR_MOVE, 8'h02);
    test_done();
  end
endmodule : rie_interval_events_bench
